// File: verilog/exc_entry_pkg.sv
// Package with register map, field positions and timing counts.
package exc_entry_pkg;
  // Register byte address of the context control register.
  localparam logic [31:0] fp_context_control_addr = 32'he000ef34;
  // Lazy stacking enable bit position.
  localparam int          lazy_stack_enable_bit   = 30;
  // Automatic floating-point stacking enable bit position.
  localparam int          auto_stack_enable_bit   = 31;
  // Reset value: both enables on.
  localparam logic [31:0] fp_context_control_rst  = 32'hc0000000;
  // Status register of my choosing (read-only hazard view).
  localparam logic [31:0] hazard_status_addr      = 32'he000ef80;
  // Long floating-point operation length in cycles.
  localparam int          fp_long_op_cycles       = 14;
  // Least entry latency with lazy stacking on.
  localparam int          entry_min_cycles        = 12;
  // Stack words pushed on entry (integer frame).
  localparam int          stack_frame_words       = 8;
  // Extra words pushed when the float context is saved.
  localparam int          fp_frame_words          = 18;
  // Instruction count at or below which a handler is short.
  localparam int          short_handler_instrs    = 2;
endpackage

// File: verilog/exc_op_timer.sv
// Countdown timer used for the long float operation and the entry latency.
`timescale 1ns/1ps
module exc_op_timer #(
  parameter int width = 5
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [width-1:0] load_value,
  output logic                  busy,
  output logic                  done
);
  // Remaining cycles and its next value.
  logic [width-1:0] count_r;
  logic [width-1:0] count_nxt;
  // One-cycle pulse when the count reaches zero.
  logic             done_r;
  logic             done_nxt;

  // Next count: load wins, otherwise step down while nonzero.
  always_comb
  begin
    count_nxt = count_r;
    done_nxt  = 1'b0;
    if (load)
    begin
      count_nxt = load_value;
    end
    else if (count_r != '0)
    begin
      count_nxt = count_r - 1'b1;
      done_nxt  = (count_r == {{(width-1){1'b0}}, 1'b1});
    end
  end

  // Register the countdown state.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count_r <= '0;
      done_r  <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      done_r  <= done_nxt;
    end
  end

  assign busy = (count_r != '0);
  assign done = done_r;
endmodule

// File: verilog/exc_entry_core.sv
// Exception entry hazard model: long float ops, lazy stacking, load replay.
//
// Overview of operation
// [RL1] Divide and square root take fourteen cycles.
// [RL2] Accepted interrupt never aborts running divide.
// [RL3] Lazy mode defers float stacking to handler.
// [RL4] Lazy stacking enabled out of reset.
// [RL5] Lazy entry needs at least twelve cycles.
// [RL6] Clearing control bit 30 disables lazy.
// [RL7] Short handler may lose divide result.
// [RL8] Wait-stated stack transactions avoid result loss.
// [RL9] Interrupted stack-pointer load replays after return.
// [RL10] Write-back forms update base every execution.
// [RL11] Replay to device memory reads twice.
// [RL12] Indirect load through register avoids both.
`timescale 1ns/1ps
module exc_entry_core #(
  parameter int op_cycles    = exc_entry_pkg::fp_long_op_cycles,
  parameter int entry_cycles = exc_entry_pkg::entry_min_cycles
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_req,
  input  wire logic        exc_return,
  input  wire logic        fp_divide_op,
  input  wire logic        fp_square_root_op,
  input  wire logic        handler_fp_instr,
  input  wire logic        handler_short,
  input  wire logic        stack_wait_state,
  input  wire logic        word_load_op,
  input  wire logic        load_to_sp,
  input  wire logic        load_writeback,
  input  wire logic        load_device_mem,
  input  wire logic        load_addr_issued,
  input  wire logic        load_data_valid,
  output logic             irq_accept,
  output logic             handler_start,
  output logic             fp_stack_push,
  output logic             fp_result_write,
  output logic             fp_result_lost,
  output logic             load_replay,
  output logic             base_update,
  output logic             device_reread
);
  // Timer widths derived from the cycle counts.
  localparam int tw = $clog2(op_cycles + 1);
  localparam int ew = $clog2(entry_cycles + 1);

  initial
  begin
    if (op_cycles < 3 || entry_cycles < 3)
    begin
      $error("exc_entry_core: cycle counts must be at least 3");
    end
  end

  // Entry states.
  typedef enum logic [1:0] {st_run, st_stack, st_handler} entry_st_t;

  // Control register (lazy/automatic enables), reset with lazy on.
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  entry_st_t   st_r;
  entry_st_t   st_nxt;
  // Float context saved for this handler already.
  logic        fp_saved_r;
  logic        fp_saved_nxt;
  // A stack-pointer load was interrupted and must replay.
  logic        replay_pend_r;
  logic        replay_pend_nxt;
  logic        replay_wb_r;
  logic        replay_wb_nxt;
  logic        replay_dev_r;
  logic        replay_dev_nxt;
  // Registered outputs.
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [7:0]  out_r;
  logic [7:0]  out_nxt;
  // Timer handshakes.
  logic        op_load;
  logic        op_busy;
  logic        op_done;
  logic        ent_load;
  logic        ent_busy;
  logic        ent_done;
  logic        lazy_on;
  logic        acc_phase;

  assign lazy_on   = ctrl_r[exc_entry_pkg::lazy_stack_enable_bit];
  assign acc_phase = psel && penable && !pready_r;

  // Returns 1 when the bus address hits a given register.
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  // Loaded two short: the done flop and the output flop add two cycles.
  exc_op_timer #(.width(tw)) op_timer (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (op_load),
    .load_value (tw'(op_cycles - 2)),
    .busy       (op_busy),
    .done       (op_done)
  );

  // Entry latency timer, also two short for the same two flop stages.
  exc_op_timer #(.width(ew)) ent_timer (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .load       (ent_load),
    .load_value (ew'(entry_cycles - 2)),
    .busy       (ent_busy),
    .done       (ent_done)
  );

  // A new op starts only when none is running, so no abort is possible.
  assign op_load  = (fp_divide_op || fp_square_root_op) && !op_busy; // RL1
  assign ent_load = (st_r == st_run) && irq_req;

  // APB slave: one wait cycle, pslverr on unmapped addresses.
  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (acc_phase)
    begin
      pready_nxt = 1'b1;
      if (hit(paddr, exc_entry_pkg::fp_context_control_addr))
      begin
        // Only the two enable bits are writable; others read zero.
        if (pwrite)
        begin
          ctrl_nxt = pwdata & exc_entry_pkg::fp_context_control_rst; // RL6
        end
        prdata_nxt = ctrl_r;
      end
      else if (hit(paddr, exc_entry_pkg::hazard_status_addr))
      begin
        prdata_nxt = {21'h0, replay_dev_r, replay_wb_r, replay_pend_r,
                      fp_saved_r, op_busy, st_r, out_r[3:0]};
        pslverr_nxt = pwrite;
      end
      else
      begin
        prdata_nxt  = 32'h0;
        pslverr_nxt = 1'b1;
      end
    end
  end

  // Entry, lazy stacking, result hazard and load replay.
  always_comb
  begin
    st_nxt          = st_r;
    fp_saved_nxt    = fp_saved_r;
    replay_pend_nxt = replay_pend_r;
    replay_wb_nxt   = replay_wb_r;
    replay_dev_nxt  = replay_dev_r;
    out_nxt         = 8'h0;
    case (st_r)
      st_run:
      begin
        if (irq_req)
        begin
          out_nxt[0]   = 1'b1;
          st_nxt       = st_stack;
          fp_saved_nxt = 1'b0;
          // Address issued but data not back: the load replays later.
          if (word_load_op && load_to_sp && load_addr_issued &&
              !load_data_valid) // RL9 RL12
          begin
            replay_pend_nxt = 1'b1;
            replay_wb_nxt   = load_writeback;  // RL10
            replay_dev_nxt  = load_device_mem; // RL11
          end
          // Without lazy mode the float frame goes out with the stack.
          if (!lazy_on)
          begin
            out_nxt[2]   = 1'b1;
            fp_saved_nxt = 1'b1;
          end
        end
        else if (replay_pend_r)
        begin
          // Re-execute the load; write-back forms move the base again.
          out_nxt[5]      = 1'b1;
          out_nxt[6]      = replay_wb_r;  // RL10
          out_nxt[7]      = replay_dev_r; // RL11
          replay_pend_nxt = 1'b0;
        end
      end
      st_stack:
      begin
        // The first handler instruction waits for the full latency.
        if (ent_done) // RL5
        begin
          out_nxt[1] = 1'b1;
          st_nxt     = st_handler;
        end
      end
      st_handler:
      begin
        // Deferred float push on the handler's first float instruction.
        if (handler_fp_instr && lazy_on && !fp_saved_r) // RL3
        begin
          out_nxt[2]   = 1'b1;
          fp_saved_nxt = 1'b1;
        end
        if (exc_return)
        begin
          st_nxt = st_run;
        end
      end
      default:
      begin
        st_nxt = st_run;
      end
    endcase
    // The op runs in parallel with stacking and completes in the handler. A lazy, short handler
    // with zero-wait stacking returns before write-back and loses it.
    if (op_done)
    begin
      if ((st_r == st_handler) && exc_return && handler_short && lazy_on &&
          !fp_saved_r && !stack_wait_state) // RL7 RL8
      begin
        out_nxt[4] = 1'b1;
      end
      else
      begin
        out_nxt[3] = 1'b1; // RL2
      end
    end
  end

  // Register all state; lazy enable is on after reset.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r        <= exc_entry_pkg::fp_context_control_rst; // RL4
      st_r          <= st_run;
      fp_saved_r    <= 1'b0;
      replay_pend_r <= 1'b0;
      replay_wb_r   <= 1'b0;
      replay_dev_r  <= 1'b0;
      prdata_r      <= 32'h0;
      pready_r      <= 1'b0;
      pslverr_r     <= 1'b0;
      out_r         <= 8'h0;
    end
    else
    begin
      ctrl_r        <= ctrl_nxt;
      st_r          <= st_nxt;
      fp_saved_r    <= fp_saved_nxt;
      replay_pend_r <= replay_pend_nxt;
      replay_wb_r   <= replay_wb_nxt;
      replay_dev_r  <= replay_dev_nxt;
      prdata_r      <= prdata_nxt;
      pready_r      <= pready_nxt;
      pslverr_r     <= pslverr_nxt;
      out_r         <= out_nxt;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign irq_accept      = out_r[0];
  assign handler_start   = out_r[1];
  assign fp_stack_push   = out_r[2];
  assign fp_result_write = out_r[3];
  assign fp_result_lost  = out_r[4];
  assign load_replay     = out_r[5];
  assign base_update     = out_r[6];
  assign device_reread   = out_r[7];

  // Register-level load to a GPR does not set the replay, so the
  // indirect form is immune. RL12 depends on load_to_sp being low.

  // Named start and end steps of a long operation.
  sequence op_start_s;
    op_load;
  endsequence
  sequence op_end_s;
    ##(14) (fp_result_write || fp_result_lost);
  endsequence

  op_length_a: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    op_start_s |-> op_end_s)
    else $error("long float op did not end after 14 cycles");
  op_no_abort_a: assert property (@(posedge clk_sys) disable iff (rst) // RL2
    (op_busy && irq_accept) |-> ##[1:14] (fp_result_write || fp_result_lost))
    else $error("long float op aborted by interrupt");
  entry_latency_a: assert property (@(posedge clk_sys) // RL5
    disable iff (rst)
    irq_accept |-> !handler_start [*8] ##1 !handler_start [*3])
    else $error("handler started before 12 cycles");
  lazy_defer_a: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    (irq_accept && $past(lazy_on)) |-> !fp_stack_push)
    else $error("float context stacked at entry in lazy mode");
  lazy_reset_a: assert property (@(posedge clk_sys) // RL4
    $rose(!rst) |-> lazy_on)
    else $error("lazy stacking not enabled after reset");
  eager_push_a: assert property (@(posedge clk_sys) disable iff (rst) // RL6
    (irq_accept && !$past(lazy_on)) |-> fp_stack_push)
    else $error("float context not stacked with lazy off");
  loss_wait_a: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    fp_result_lost |-> !$past(stack_wait_state))
    else $error("result lost despite wait-stated stacking");
  loss_cause_a: assert property (@(posedge clk_sys) disable iff (rst) // RL7
    fp_result_lost |-> $past(handler_short) && !fp_result_write)
    else $error("result lost without a short handler");
  replay_once_a: assert property (@(posedge clk_sys) disable iff (rst) // RL9
    load_replay |=> !replay_pend_r)
    else $error("stack-pointer load replay not consumed");
  base_twice_a: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    base_update |-> load_replay)
    else $error("base update without replay");
  dev_reread_a: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    device_reread |-> load_replay)
    else $error("device reread without replay");
endmodule

// File: testbench/irq_mem_model.sv
// Interrupt source and stack memory model facing the entry block.
`timescale 1ns/1ps
module irq_mem_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic fire,
  input  wire logic slow,
  input  wire logic irq_accept,
  output logic      irq_req,
  output logic      stack_wait_state
);
  // The request is held until the core accepts it, as a real source does.
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      irq_req <= 1'b0;
    else if (fire)
      irq_req <= 1'b1;
    else if (irq_accept)
      irq_req <= 1'b0;
  // A slow memory adds wait states to every stack transaction.
  assign stack_wait_state = slow;
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the exception entry hazard block.
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq_req, stack_wait_state;
  logic        fire = 1'b0, slow = 1'b0, exc_return = 1'b0;
  logic        fp_divide_op = 1'b0, fp_square_root_op = 1'b0;
  logic        handler_fp_instr = 1'b0, handler_short = 1'b0;
  logic        word_load_op = 1'b0, load_to_sp = 1'b0;
  logic        load_writeback = 1'b0, load_device_mem = 1'b0;
  logic        load_addr_issued = 1'b0, load_data_valid = 1'b0;
  logic        irq_accept, handler_start, fp_stack_push;
  logic        fp_result_write, fp_result_lost;
  logic        load_replay, base_update, device_reread;
  int          seed = 32'h8a880f65;
  int          err_total = 0, compares = 0, cyc = 0;
  int          t_irq, t_op, t_acc, t_hs, t_push, t_fin;
  int          cnt[6];
  logic [31:0] rd, w;
  logic        er;
  bit          lazy;

  exc_entry_core uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_req, .exc_return,
    .fp_divide_op, .fp_square_root_op, .handler_fp_instr, .handler_short,
    .stack_wait_state, .word_load_op, .load_to_sp, .load_writeback,
    .load_device_mem, .load_addr_issued, .load_data_valid, .irq_accept,
    .handler_start, .fp_stack_push, .fp_result_write, .fp_result_lost,
    .load_replay, .base_update, .device_reread);

  irq_mem_model partner (.clk_sys, .rst, .fire, .slow, .irq_accept,
    .irq_req, .stack_wait_state);

  // Free-running clock at 250 MHz.
  always #2 clk_sys = ~clk_sys;

  // Monitor stamps events with the edge at which they were sampled; fire with the edge after.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      err_total++;
      end_sim;
    end
    if (fire) t_irq = cyc + 1;
    if (fp_divide_op || fp_square_root_op) t_op = cyc;
    if (irq_accept) t_acc = cyc;
    if (handler_start) t_hs = cyc;
    if (fp_stack_push) t_push = cyc;
    if (fp_result_write || fp_result_lost) t_fin = cyc;
    cnt[0] += fp_stack_push;
    cnt[1] += fp_result_write;
    cnt[2] += fp_result_lost;
    cnt[3] += load_replay;
    cnt[4] += base_update;
    cnt[5] += device_reread;
  end

  // Compares one value; case equality, so an unknown bit matches only an unknown expected bit.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One bus transfer; request held until pready is sampled high.
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && n++ < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Random choice of divide or square root.
  function int rop();
    return ($random(seed) & 1) + 1;
  endfunction

  // One exception: optional long op started with the request, a load in
  // flight, then a return. The model's expectations follow the rules.
  task entry(input int op, input logic sh, ws, fpi, sp, wb, dev);
    int  n;
    logic lost;
    n = 0;
    cnt = '{default: 0};
    slow <= ws;
    handler_short <= sh;
    word_load_op <= 1'b1;
    load_to_sp <= sp;
    load_writeback <= wb;
    load_device_mem <= dev;
    load_addr_issued <= 1'b1;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    fp_divide_op <= (op == 1);
    fp_square_root_op <= (op == 2);
    @(posedge clk_sys);
    fp_divide_op <= 1'b0;
    fp_square_root_op <= 1'b0;
    do @(posedge clk_sys); while (handler_start !== 1'b1 && n++ < 40);
    // Returning at once makes the return land on the result's edge.
    handler_fp_instr <= fpi;
    exc_return <= ~fpi;
    @(posedge clk_sys);
    handler_fp_instr <= 1'b0;
    exc_return <= fpi;
    @(posedge clk_sys);
    exc_return <= 1'b0;
    load_addr_issued <= 1'b0;
    repeat (20) @(posedge clk_sys);
    lost = (op != 0) && sh && !ws && lazy && !fpi;
    chk(t_acc - t_irq, 1);
    chk(t_hs - t_irq, 12);
    chk(cnt[0], 32'(fpi | !lazy));
    if (!lazy) chk(t_push - t_irq, 1);
    if (op != 0)
    begin
      chk(t_fin - t_op, 14);
      chk(cnt[2], 32'(lost));
      chk(cnt[1], 32'(!lost));
    end
    chk(cnt[3], 32'(sp));
    chk(cnt[4], 32'(sp & wb));
    chk(cnt[5], 32'(sp & dev));
  endtask

  // Main sequence: registers first, then entries, then lazy off.
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    lazy = 1'b1;
    apb(1'b0, exc_entry_pkg::fp_context_control_addr, 32'h0);
    chk(rd, 32'hc0000000);
    apb(1'b0, 32'he000ef00, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, exc_entry_pkg::hazard_status_addr, $random(seed));
    chk({31'h0, er}, 32'h1);
    w = $random(seed);
    apb(1'b1, exc_entry_pkg::fp_context_control_addr, w);
    apb(1'b0, exc_entry_pkg::fp_context_control_addr, 32'h0);
    chk(rd, w & 32'hc0000000);
    apb(1'b1, exc_entry_pkg::fp_context_control_addr, 32'hc0000000);
    entry(rop(), 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    entry(rop(), 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    entry(rop(), 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    // Plain, write-back, device memory, then the indirect form.
    for (int i = 0; i < 4; i++)
      entry(0, 1'b0, 1'b0, 1'b0, i != 3, i == 1 || i == 3, i >= 2);
    apb(1'b1, exc_entry_pkg::fp_context_control_addr, 32'h80000000);
    lazy = 1'b0;
    entry(rop(), 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    end_sim;
  end
endmodule
